// file: shared/swb_pkg.sv
/*
  Constants, register map and slot timing for the single-wire bit and byte
  write engine. Assumes a 40 MHz core clock; all counts are derived from it.
*/
// Contract
// - Code 87h plus one parameter byte yields exactly one bus slot.
// - Slot value is parameter bit 7; bits 6 to 0 are ignored.
// - Value zero gives a write-zero slot, value one a write-one/read slot.
// - Line level is sampled at the read sample point into single_bit_result.
// - Single-bit command arriving while busy is not acknowledged and dropped.
// - Single-bit command finishes within one slot plus 262.5 ns.
// - Single-bit bus activity starts at most 262.5 ns after parameter arrives.
// - After a single-bit command the read pointer selects status.
// - Busy stays high one slot; result updates at the sample point.
// - Single-bit command honours speed, active and strong pullup settings.
// - Code A5h plus one data byte writes that byte onto the bus.
// - Byte write equals eight consecutive single-bit slots.
// - Byte bits go out least significant first, after the whole byte.
// - Byte write activity starts at most 262.5 ns after the byte arrives.
// - Byte write finishes within eight slots plus 262.5 ns; busy meanwhile.
// - Byte write arriving while busy is not acknowledged and dropped.
// - After a byte write the read pointer selects status.
// - Byte write honours speed, strong and active pullup settings.
package swb_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  typedef logic [ADDR_W-1:0] swb_addr_t;
  typedef logic [DATA_W-1:0] swb_data_t;

  localparam swb_addr_t ADDR_CMD = 4'h0;
  localparam swb_addr_t ADDR_STATUS = 4'h4;
  localparam swb_addr_t ADDR_CONFIG = 4'h8;
  localparam swb_addr_t ADDR_RDPTR = 4'hc;

  localparam logic [7:0] CODE_SINGLE_BIT = 8'h87;
  localparam logic [7:0] CODE_WRITE_BYTE = 8'ha5;
  localparam int unsigned BIT_VALUE_POS = 7;

  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_SBR = 1;
  localparam int unsigned ST_NACK = 2;
  localparam int unsigned CFG_APU = 0;
  localparam int unsigned CFG_SPU = 2;
  localparam int unsigned CFG_OVD = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;

  localparam logic [7:0] RP_STATUS = 8'hf0;
  localparam logic [7:0] RP_CONFIG = 8'hc3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned FIFO_W = 2;
  localparam int unsigned FIFO_D = 16;

  // Timing in ps so 262.5 ns stays exact
  localparam int unsigned CLK_PS = 25000;
  localparam int unsigned T_ACT_MAX_PS = 262500;
  localparam int unsigned ACT_MAX_CYC = T_ACT_MAX_PS / CLK_PS;
  localparam int unsigned T_STD_SLOT_NS = 70000;
  localparam int unsigned T_STD_LOW0_NS = 60000;
  localparam int unsigned T_STD_LOW1_NS = 6000;
  localparam int unsigned T_STD_MSR_NS = 15000;
  localparam int unsigned T_OVD_SLOT_NS = 10000;
  localparam int unsigned T_OVD_LOW0_NS = 8000;
  localparam int unsigned T_OVD_LOW1_NS = 1000;
  localparam int unsigned T_OVD_MSR_NS = 2000;
  localparam int unsigned T_APU_NS = 1000;
  localparam int unsigned CNT_W = 12;
  typedef logic [CNT_W-1:0] swb_cnt_t;
  localparam swb_cnt_t STD_SLOT_CYC = CNT_W'((T_STD_SLOT_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam swb_cnt_t STD_LOW0_CYC = CNT_W'((T_STD_LOW0_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam swb_cnt_t STD_LOW1_CYC = CNT_W'((T_STD_LOW1_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam swb_cnt_t STD_MSR_CYC = CNT_W'((T_STD_MSR_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam swb_cnt_t OVD_SLOT_CYC = CNT_W'((T_OVD_SLOT_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam swb_cnt_t OVD_LOW0_CYC = CNT_W'((T_OVD_LOW0_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam swb_cnt_t OVD_LOW1_CYC = CNT_W'((T_OVD_LOW1_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam swb_cnt_t OVD_MSR_CYC = CNT_W'((T_OVD_MSR_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam swb_cnt_t APU_CYC = CNT_W'((T_APU_NS * 1000 + CLK_PS - 1) / CLK_PS);
endpackage

// file: hdl/swb_fifo.sv
/*
  Small synchronous FIFO between the command engine and the slot generator.
  Assumes one clock; read data is the head entry held in flip-flops.
*/
`timescale 1ns/1ps
module swb_fifo #(
  parameter int unsigned W = 2,
  parameter int unsigned D = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int unsigned PW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = cnt_q != (PW+1)'(D);
  assign o_out_valid = cnt_q != '0;
  assign o_out_data = mem_q[rd_ptr_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// file: hdl/swb_slot_gen.sv
/*
  Generates one timed bus slot per accepted bit and samples the line.
  Assumes the line input is already synchronous to the core clock.
*/
`timescale 1ns/1ps
module swb_slot_gen
  import swb_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic i_bit,
  input wire logic i_last,
  input wire logic i_ovd,
  input wire logic i_apu,
  input wire logic i_spu,
  input wire logic i_line_in,
  output logic o_busy,
  output logic o_line_oe,
  output logic o_active_pullup,
  output logic o_strong_pullup,
  output logic o_sample_valid,
  output logic o_sample
);
  typedef enum logic {SG_IDLE, SG_SLOT} swb_sg_state_t;
  swb_sg_state_t state_q;
  swb_cnt_t cnt_q;
  swb_cnt_t low_q;
  swb_cnt_t slot_q;
  swb_cnt_t msr_q;
  logic last_q;
  logic spu_q;
  logic start;

  assign o_ready = state_q == SG_IDLE;
  assign start = i_valid && o_ready;
  assign o_busy = state_q == SG_SLOT;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= SG_IDLE;
      cnt_q <= '0;
      low_q <= '0;
      slot_q <= '0;
      msr_q <= '0;
      last_q <= 1'b0;
    end else begin
      unique case (state_q)
        SG_IDLE: begin
          if (start) begin
            state_q <= SG_SLOT;
            cnt_q <= '0;
            last_q <= i_last;
            // Speed selection picks the whole slot shape
            slot_q <= i_ovd ? OVD_SLOT_CYC : STD_SLOT_CYC;
            msr_q <= i_ovd ? OVD_MSR_CYC : STD_MSR_CYC;
            if (i_bit) low_q <= i_ovd ? OVD_LOW1_CYC : STD_LOW1_CYC;
            else low_q <= i_ovd ? OVD_LOW0_CYC : STD_LOW0_CYC;
          end
        end
        SG_SLOT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == slot_q - 1'b1) state_q <= SG_IDLE;
        end
      endcase
    end
  end

  // Strong pullup holds the line after the last slot until the next slot
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      spu_q <= 1'b0;
    end else if (start) begin
      spu_q <= 1'b0;
    end else if (o_busy && cnt_q == slot_q - 1'b1 && last_q && i_spu) begin
      spu_q <= 1'b1;
    end
  end
  assign o_strong_pullup = spu_q;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_line_oe <= 1'b0;
      o_active_pullup <= 1'b0;
      o_sample_valid <= 1'b0;
      o_sample <= 1'b0;
    end else begin
      // Slot starts the cycle after the bit leaves the queue
      o_line_oe <= start || (o_busy && cnt_q + 1'b1 < low_q);
      o_active_pullup <= i_apu && o_busy && cnt_q + 1'b1 >= low_q
                         && cnt_q + 1'b1 < low_q + APU_CYC;
      o_sample_valid <= o_busy && cnt_q == msr_q;
      o_sample <= i_line_in;
    end
  end

  property p_zero_low;
    @(posedge i_core_clk) disable iff (i_rst)
    start && !i_bit |=> o_line_oe [*8];
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("write-zero slot not held low");

  property p_busy_slot;
    @(posedge i_core_clk) disable iff (i_rst)
    start |=> o_busy [*8];
  endproperty
  a_busy_slot: assert property (p_busy_slot) else $error("slot busy dropped early");
endmodule

// file: hdl/swb_top.sv
/*
  Single-wire bit and byte write engine behind an AXI4-Lite register slave.
  Assumes a 40 MHz core clock, an external open-drain line driver and a
  line input already synchronous to the core clock.
*/
`timescale 1ns/1ps
module swb_top (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire swb_pkg::swb_addr_t i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire swb_pkg::swb_data_t i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire swb_pkg::swb_addr_t i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output swb_pkg::swb_data_t o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_line_in,
  output logic o_line_out,
  output logic o_line_oe,
  output logic o_active_pullup,
  output logic o_strong_pullup,
  output logic o_line_busy
);
  import swb_pkg::*;

  logic aw_held_q;
  logic w_held_q;
  swb_addr_t awaddr_q;
  swb_data_t wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  swb_data_t rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic rd_go;
  logic wr_mapped;
  logic rd_mapped;

  logic cmd_go;
  logic [7:0] cmd_code;
  logic [7:0] cmd_param;
  logic cmd_known;
  logic cmd_accept;
  logic [15:0] last_cmd_q;
  logic [3:0] cfg_q;
  logic [7:0] rdptr_q;
  logic nack_q;
  logic sbr_q;
  logic busy;

  logic [7:0] eng_bits_q;
  logic [3:0] eng_cnt_q;
  logic push_valid;
  logic push_ready;
  logic [FIFO_W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [FIFO_W-1:0] pop_data;
  logic slot_busy;
  logic sample_valid;
  logic sample;

  // AXI4-Lite write side: address and data may arrive in either order
  assign o_awready = !aw_held_q && !bvalid_q;
  assign o_wready = !w_held_q && !bvalid_q;
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign wr_mapped = awaddr_q == ADDR_CMD || awaddr_q == ADDR_STATUS
                     || awaddr_q == ADDR_CONFIG || awaddr_q == ADDR_RDPTR;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= i_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (i_wvalid && o_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= i_wdata;
      wstrb_q <= i_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // AXI4-Lite read side
  assign o_arready = !rvalid_q;
  assign rd_go = i_arvalid && o_arready;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign rd_mapped = i_araddr == ADDR_CMD || i_araddr == ADDR_STATUS
                     || i_araddr == ADDR_CONFIG || i_araddr == ADDR_RDPTR;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= '0;
      unique case (i_araddr)
        ADDR_CMD: rdata_q[15:0] <= last_cmd_q;
        ADDR_STATUS: begin
          rdata_q[ST_BUSY] <= busy;
          rdata_q[ST_SBR] <= sbr_q;
          rdata_q[ST_NACK] <= nack_q;
        end
        // Upper nibble reads as zero
        ADDR_CONFIG: rdata_q[3:0] <= cfg_q;
        ADDR_RDPTR: rdata_q[7:0] <= rdptr_q;
        default: rdata_q <= '0;
      endcase
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Command path: one write of code and parameter stands for both bytes
  assign cmd_code = wdata_q[15:8];
  assign cmd_param = wdata_q[7:0];
  assign cmd_go = wr_go && awaddr_q == ADDR_CMD && wstrb_q[1:0] == 2'b11;
  assign cmd_known = cmd_code == CODE_SINGLE_BIT || cmd_code == CODE_WRITE_BYTE;
  // Busy covers queued bits too, so a command can never overtake a slot
  assign busy = eng_cnt_q != '0 || pop_valid || slot_busy;
  assign cmd_accept = cmd_go && !busy && cmd_known;
  assign o_line_busy = busy;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      eng_bits_q <= '0;
      eng_cnt_q <= '0;
    end else if (cmd_accept) begin
      if (cmd_code == CODE_SINGLE_BIT) begin
        eng_bits_q <= {7'h00, cmd_param[BIT_VALUE_POS]};
        eng_cnt_q <= 4'h1;
      end else begin
        // Whole byte is in hand, so it can leave least significant first
        eng_bits_q <= cmd_param;
        eng_cnt_q <= 4'h8;
      end
    end else if (push_valid && push_ready) begin
      eng_bits_q <= {1'b0, eng_bits_q[7:1]};
      eng_cnt_q <= eng_cnt_q - 1'b1;
    end
  end

  assign push_valid = eng_cnt_q != '0;
  assign push_data = {eng_cnt_q == 4'h1, eng_bits_q[0]};

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      last_cmd_q <= '0;
    end else if (cmd_accept) begin
      last_cmd_q <= wdata_q[15:0];
    end
  end

  // Refused command sets the not-acknowledged flag; a new refusal wins over clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      nack_q <= 1'b0;
    end else if (cmd_go && !cmd_accept) begin
      nack_q <= 1'b1;
    end else if (wr_go && awaddr_q == ADDR_STATUS && wstrb_q[0] && wdata_q[ST_NACK]) begin
      nack_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= CFG_RESET;
    end else if (wr_go && awaddr_q == ADDR_CONFIG && wstrb_q[0] && !busy) begin
      cfg_q <= wdata_q[3:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdptr_q <= RP_STATUS;
    end else if (cmd_accept) begin
      rdptr_q <= RP_STATUS;
    end else if (wr_go && awaddr_q == ADDR_CONFIG && wstrb_q[0] && !busy) begin
      rdptr_q <= RP_CONFIG;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sbr_q <= 1'b0;
    end else if (sample_valid) begin
      sbr_q <= sample;
    end
  end

  swb_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_data),
    .o_out_valid(pop_valid),
    .i_out_ready(pop_ready),
    .o_out_data(pop_data)
  );

  swb_slot_gen u_slot (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_valid(pop_valid),
    .o_ready(pop_ready),
    .i_bit(pop_data[0]),
    .i_last(pop_data[1]),
    .i_ovd(cfg_q[CFG_OVD]),
    .i_apu(cfg_q[CFG_APU]),
    .i_spu(cfg_q[CFG_SPU]),
    .i_line_in(i_line_in),
    .o_busy(slot_busy),
    .o_line_oe(o_line_oe),
    .o_active_pullup(o_active_pullup),
    .o_strong_pullup(o_strong_pullup),
    .o_sample_valid(sample_valid),
    .o_sample(sample)
  );

  // Open-drain line: only ever pulled low
  assign o_line_out = 1'b0;

  sequence s_single_go;
    cmd_accept && cmd_code == CODE_SINGLE_BIT;
  endsequence
  sequence s_byte_go;
    cmd_accept && cmd_code == CODE_WRITE_BYTE;
  endsequence

  property p_refuse_busy;
    @(posedge i_core_clk) disable iff (i_rst)
    cmd_go && busy |=> nack_q && eng_cnt_q <= $past(eng_cnt_q) && $stable(last_cmd_q);
  endproperty
  a_refuse_busy: assert property (p_refuse_busy) else $error("busy command not refused");

  property p_single_start;
    @(posedge i_core_clk) disable iff (i_rst)
    s_single_go |-> ##[1:10] o_line_oe;
  endproperty
  a_single_start: assert property (p_single_start) else $error("single bit slot late");

  property p_byte_start;
    @(posedge i_core_clk) disable iff (i_rst)
    s_byte_go |-> ##[1:10] o_line_oe;
  endproperty
  a_byte_start: assert property (p_byte_start) else $error("byte write slot late");

  property p_bit7;
    @(posedge i_core_clk) disable iff (i_rst)
    s_single_go |=> eng_cnt_q == 4'h1 && eng_bits_q[0] == $past(cmd_param[7]);
  endproperty
  a_bit7: assert property (p_bit7) else $error("slot value not bit 7");

  property p_lsb_first;
    @(posedge i_core_clk) disable iff (i_rst)
    s_byte_go |=> eng_cnt_q == 4'h8 && push_data[0] == $past(cmd_param[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("byte not sent lsb first");

  property p_rdptr;
    @(posedge i_core_clk) disable iff (i_rst)
    cmd_accept |=> rdptr_q == RP_STATUS;
  endproperty
  a_rdptr: assert property (p_rdptr) else $error("read pointer not on status");

  property p_sbr;
    @(posedge i_core_clk) disable iff (i_rst)
    sample_valid |=> sbr_q == $past(sample);
  endproperty
  a_sbr: assert property (p_sbr) else $error("result flag not updated");

  property p_busy_after;
    @(posedge i_core_clk) disable iff (i_rst)
    cmd_accept |=> busy [*8];
  endproperty
  a_busy_after: assert property (p_busy_after) else $error("busy not held");
endmodule

// file: verif/swb_line_model.sv
/*
  Behavioural slave on the single-wire line: pull-up, optional answer-zero
  pull during a slot, and a decoder of written bits by low-phase length.
  Assumes the engine drives the line low only while its output enable is high.
*/
`timescale 1ns/1ps
module swb_line_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_oe,
  input wire logic i_ovd,
  input wire logic i_answer_zero,
  output logic o_line,
  output logic [7:0] o_bits,
  output int o_slots
);
  int low_q;
  int pull_q;
  logic oe_q;
  // Released line goes to the pull-up level; the slave pull wins over it
  assign o_line = !i_oe && (pull_q == 0);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      low_q <= 0;
      pull_q <= 0;
      oe_q <= 1'b0;
      o_bits <= 8'h00;
      o_slots <= 0;
    end else begin
      oe_q <= i_oe;
      if (i_oe) begin
        low_q <= low_q + 1;
      end
      // Hold covers the sample point at either speed but ends inside the slot
      if (i_oe && !oe_q) begin
        pull_q <= i_answer_zero ? (i_ovd ? 100 : 1000) : 0;
      end else if (pull_q != 0) begin
        pull_q <= pull_q - 1;
      end
      // Short low phase is a one; bits arrive lsb first, so shift in at the top
      if (!i_oe && oe_q) begin
        o_bits <= {low_q < (i_ovd ? 150 : 1000), o_bits[7:1]};
        o_slots <= o_slots + 1;
        low_q <= 0;
      end
    end
  end
endmodule

// file: verif/single_wire_bit_byte_write_tb.sv
/*
  Self-checking bench: AXI4-Lite register tasks drive bit and byte commands.
  Assumes the line model above as the only device on the single-wire line.
*/
`timescale 1ns/1ps
module single_wire_bit_byte_write_tb;
  import swb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  swb_addr_t awaddr = '0, araddr = '0;
  swb_data_t wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, line_in, line_out, oe, active_pullup_enable, strong_pullup_enable, busy;
  logic [1:0] bresp, rresp, r;
  logic ovd = 1'b0, ans0 = 1'b0, oe_seen, armed, apu_seen, spu_seen;
  logic [7:0] bits;
  int slots, busy_cnt, lat, base, i;
  int bad_count = 0;
  int checks_done = 0;
  logic [7:0] pars [3] = '{8'h80, 8'h7f, 8'hff};
  logic az [3] = '{1'b0, 1'b0, 1'b1};
  logic vexp [3] = '{1'b1, 1'b0, 1'b1};
  logic sexp [3] = '{1'b1, 1'b0, 1'b0};
  always #12.5 clk = ~clk;
  swb_top dut (.i_core_clk(clk), .i_rst(rst), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
    .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .i_line_in(line_in), .o_line_out(line_out),
    .o_line_oe(oe), .o_active_pullup(active_pullup_enable), .o_strong_pullup(strong_pullup_enable), .o_line_busy(busy));
  swb_line_model line (.i_core_clk(clk), .i_rst(rst), .i_oe(oe), .i_ovd(ovd),
    .i_answer_zero(ans0), .o_line(line_in), .o_bits(bits), .o_slots(slots));
  // Sampled mid-cycle so design updates at the rising edge have settled
  always @(negedge clk) begin
    if (busy) busy_cnt++;
    if (bvalid && !oe_seen) armed = 1'b1;
    if (armed && !oe_seen) lat++;
    if (oe) oe_seen = 1'b1;
    if (active_pullup_enable) apu_seen = 1'b1;
    if (strong_pullup_enable) spu_seen = 1'b1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic hang(input string msg);
    bad_count++;
    $display("mismatch at %0t: %s", $time, msg);
    complete_run();
  endtask
  // Ready is combinational, so it is judged before the edge that takes it
  task automatic wr(input swb_addr_t a, input swb_data_t v);
    logic ah, wh, bh;
    int n;
    bh = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; bready <= 1'b1;
    for (n = 0; n < 50 && !bh; n++) begin
      @(negedge clk);
      ah = awvalid && awready; wh = wvalid && wready; bh = bvalid; r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    if (!bh) hang("write timeout");
  endtask
  task automatic rd(input swb_addr_t a);
    logic ah, hs;
    int n;
    hs = 1'b0;
    @(posedge clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (n = 0; n < 50 && !hs; n++) begin
      @(negedge clk);
      ah = arvalid && arready; hs = rvalid; d = rdata; r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (hs) rready <= 1'b0;
    end
    if (!hs) hang("read timeout");
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 10000; n++) begin
      rd(ADDR_STATUS);
      if (d[ST_BUSY] === 1'b0) return;
    end
    hang("busy never cleared");
  endtask
  task automatic clr_mon;
    @(posedge clk);
    busy_cnt = 0; lat = 0; oe_seen = 1'b0; armed = 1'b0;
    apu_seen = 1'b0; spu_seen = 1'b0; base = slots;
  endtask
  task automatic cmd(input logic [7:0] code, input logic [7:0] par);
    wr(ADDR_CMD, {16'h0000, code, par});
  endtask
  // One accepted command with the checks every command shares
  task automatic run(input logic [7:0] code, input logic [7:0] par, input int n, input int sl);
    clr_mon();
    cmd(code, par);
    wait_idle();
    chk(32'(slots - base), 32'(n), "slot count");
    chk(32'(busy_cnt >= n * sl && busy_cnt <= n * sl + ACT_MAX_CYC), 32'h1, "busy");
    chk(32'(lat <= ACT_MAX_CYC), 32'h1, "late start");
    rd(ADDR_RDPTR);
    chk(d, 32'(RP_STATUS), "pointer after command");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_STATUS);
    chk(d, 32'h0, "status reset");
    rd(ADDR_RDPTR);
    chk(d, 32'(RP_STATUS), "pointer reset");
    rd(ADDR_CONFIG);
    chk(d, 32'(CFG_RESET), "config reset");
    rd(4'h2);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped response");
    chk(d, 32'h0, "unmapped data");
    chk(32'(line_out), 32'h0, "line only pulled low");
    wr(4'h2, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped write response");
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      wr(ADDR_CONFIG, 32'h0);
      ans0 <= az[i];
      run(CODE_SINGLE_BIT, pars[i], 1, int'(STD_SLOT_CYC));
      chk(32'(bits[7]), 32'(vexp[i]), "slot kind");
      rd(ADDR_STATUS);
      chk(32'(d[ST_SBR]), 32'(sexp[i]), "sampled bit");
    end
    $display("test single bit done");
    ans0 <= 1'b0;
    clr_mon();
    cmd(CODE_SINGLE_BIT, 8'h80);
    cmd(CODE_WRITE_BYTE, 8'hff);
    chk(32'(r), 32'(RESP_OKAY), "refused write response");
    rd(ADDR_STATUS);
    chk(32'(d[ST_NACK]), 32'h1, "byte while busy");
    wr(ADDR_STATUS, 32'h4);
    cmd(CODE_SINGLE_BIT, 8'h00);
    rd(ADDR_STATUS);
    chk(32'(d[ST_NACK]), 32'h1, "bit while busy");
    wait_idle();
    chk(32'(slots - base), 32'h1, "refused commands ran");
    wr(ADDR_STATUS, 32'h4);
    cmd(8'h55, 8'h00);
    rd(ADDR_STATUS);
    chk(32'(d[ST_NACK]), 32'h1, "unknown code refused");
    chk(32'(d[ST_BUSY]), 32'h0, "unknown code started nothing");
    wr(ADDR_STATUS, 32'h4);
    rd(ADDR_STATUS);
    chk(32'(d[ST_NACK]), 32'h0, "refusal flag clear");
    $display("test refusal done");
    run(CODE_WRITE_BYTE, 8'ha6, 8, int'(STD_SLOT_CYC));
    chk(32'(bits), 32'h000000a6, "byte on line");
    rd(ADDR_CMD);
    chk(d, {16'h0000, CODE_WRITE_BYTE, 8'ha6}, "last command readback");
    $display("test byte standard done");
    wr(ADDR_CONFIG, 32'h0000000d);
    rd(ADDR_CONFIG);
    chk(d, 32'h0000000d, "config readback");
    rd(ADDR_RDPTR);
    chk(d, 32'(RP_CONFIG), "pointer after config");
    ovd <= 1'b1;
    run(CODE_WRITE_BYTE, 8'h3c, 8, int'(OVD_SLOT_CYC));
    chk(32'(bits), 32'h0000003c, "byte overdrive");
    chk(32'({apu_seen, spu_seen}), 32'h3, "byte pullups");
    run(CODE_SINGLE_BIT, 8'h00, 1, int'(OVD_SLOT_CYC));
    // Strong pullup left over from the byte is cleared at slot start, so look at it now
    chk(32'({bits[7], apu_seen, spu_seen, strong_pullup_enable}), 32'h7, "bit overdrive pullups");
    $display("test overdrive done");
    complete_run();
  end
endmodule
